// >>> rtl/tcsc_top.sv
// Functional notes
// - Eight bits, MSB first, rising clock
// - Word applied on select falling edge
// - No bit count; last eight kept
// - Respond only while own select high
// - Bit b5 set means standby
// - Low five bits: capacitance code
// - New capacitance settled within 10 us
// - Wake from standby within 100 us
`timescale 1ns/1ps
`default_nettype none
module tcsc_top (
  input wire logic mclk, // 50 MHz system clock
  input wire logic rstn, // Async active-low reset
  input wire logic serial_select, // Active-high select pin
  input wire logic serial_clock, // Shift clock pin
  input wire logic serial_data, // Serial data pin
  output logic [4:0] cap_state, // Applied capacitance code
  output logic standby_request, // Applied standby bit
  output logic apply_pulse, // One cycle on each apply
  output logic settled, // Capacitance reached target
  output logic [7:0] shift_word // Current shift contents
);
  // ------------------------------------------------------------
  // Reset release and pin synchronisers
  // ------------------------------------------------------------
  logic [1:0] rst_sync_ff;
  logic rst_n;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  logic [2:0] pins_s;
  tcsc_sync #(.WIDTH(3)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({serial_select, serial_clock, serial_data}),
    .sync_out(pins_s)
  );
  wire sel_s = pins_s[2];
  wire sclk_s = pins_s[1];
  wire sdat_s = pins_s[0];

  logic sel_d_ff;
  logic sclk_d_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sel_d_ff <= 1'b0;
      sclk_d_ff <= 1'b0;
    end else begin
      sel_d_ff <= sel_s;
      sclk_d_ff <= sclk_s;
    end
  end

  // Data held two cycles in sync stage, same as clock; sampled on clock rise
  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire shift_en = sclk_rise & sel_s;
  wire sel_fall = sel_d_ff & ~sel_s;

  // ------------------------------------------------------------
  // Shift register
  // ------------------------------------------------------------
  logic [7:0] shift_ff;
  wire [7:0] nxt_shift = shift_en ? {shift_ff[6:0], sdat_s} : shift_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= tcsc_pkg::WORD_RESET;
    end else begin
      shift_ff <= nxt_shift;
    end
  end

  // ------------------------------------------------------------
  // Applied setting
  // ------------------------------------------------------------
  tcsc_pkg::tcsc_setting_s set_ff;
  tcsc_pkg::tcsc_setting_s nxt_set;
  // Reserved b7 and b6 never reach the setting
  wire [5:0] word_set =
    shift_ff[tcsc_pkg::STANDBY_POS:tcsc_pkg::CAP_LSB_POS];
  assign nxt_set = sel_fall ? tcsc_pkg::tcsc_setting_s'(word_set)
    : set_ff;
  logic apply_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      set_ff <= '0;
      apply_ff <= 1'b0;
    end else begin
      set_ff <= nxt_set;
      apply_ff <= sel_fall;
    end
  end

  // ------------------------------------------------------------
  // Settling timer: models switching and wake-up time
  // ------------------------------------------------------------
  tcsc_pkg::tcsc_state_e st_ff;
  tcsc_pkg::tcsc_state_e nxt_st;
  logic [12:0] tmr_ff;
  logic [12:0] nxt_tmr;
  wire waking = set_ff.standby_request & ~shift_ff[tcsc_pkg::STANDBY_POS];
  wire [12:0] settle_n = 13'(tcsc_pkg::SETTLE_CYCLES - 1);
  wire [12:0] wake_n = 13'(tcsc_pkg::WAKE_CYCLES - 1);
  wire tmr_done = (tmr_ff == 13'h0000);

  always_comb begin
    nxt_st = st_ff;
    nxt_tmr = tmr_done ? tmr_ff : tmr_ff - 13'h0001;
    if (sel_fall) begin
      nxt_st = waking ? tcsc_pkg::TCSC_WAKE : tcsc_pkg::TCSC_SETTLE;
      nxt_tmr = waking ? wake_n : settle_n;
    end else begin
      case (st_ff)
        tcsc_pkg::TCSC_IDLE: nxt_st = tcsc_pkg::TCSC_IDLE;
        tcsc_pkg::TCSC_SETTLE,
        tcsc_pkg::TCSC_WAKE: begin
          if (tmr_done) begin
            nxt_st = tcsc_pkg::TCSC_IDLE;
          end
        end
        default: nxt_st = tcsc_pkg::TCSC_IDLE;
      endcase
    end
  end

  logic settled_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= tcsc_pkg::TCSC_IDLE;
      tmr_ff <= tcsc_pkg::TIMER_RESET;
      settled_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      tmr_ff <= nxt_tmr;
      settled_ff <= (nxt_st == tcsc_pkg::TCSC_IDLE);
    end
  end

  assign cap_state = set_ff.cap_state;
  assign standby_request = set_ff.standby_request;
  assign apply_pulse = apply_ff;
  assign settled = settled_ff;
  assign shift_word = shift_ff;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sequence sel_drop_s;
    sel_d_ff && !sel_s;
  endsequence

  property apply_on_fall_p;
    @(posedge mclk) disable iff (!rst_n)
      sel_drop_s |=> (cap_state == $past(shift_ff[4:0])) && apply_pulse;
  endproperty
  apply_on_fall_a: assert property (apply_on_fall_p)
    else $error("setting not applied on select fall");

  hold_between_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !sel_fall |=> $stable(set_ff))
    else $error("setting changed without select fall");

  shift_msb_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    shift_en |=> shift_ff == {$past(shift_ff[6:0]), $past(sdat_s)})
    else $error("shift order wrong");

  idle_clock_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !sel_s |=> $stable(shift_ff))
    else $error("shift moved with select low");

  standby_bit_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    sel_fall |=> standby_request == $past(shift_ff[5]))
    else $error("standby bit not taken from b5");

  settle_bound_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (sel_fall && !waking) |=> !settled ##[1:500] settled)
    else $error("settle exceeded bound");

  wake_bound_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (sel_fall && waking) ##1 !sel_fall [*8] |-> !settled)
    else $error("wake ended too soon");

  apply_once_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    apply_pulse |=> !apply_pulse)
    else $error("apply pulse longer than one cycle");

  // Count kept apart from the timer, so a wrong reload value
  // cannot hide behind the same logic that it drives
  logic [12:0] since_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      since_ff <= tcsc_pkg::TIMER_RESET;
    end else if (sel_fall) begin
      since_ff <= 13'h0000;
    end else if (!(&since_ff)) begin
      since_ff <= since_ff + 13'h0001;
    end
  end

  settle_len_a: assert property (
    @(posedge mclk) disable iff (!rst_n)
    $rose(settled) |-> (since_ff == 13'(tcsc_pkg::SETTLE_CYCLES))
      || (since_ff == 13'(tcsc_pkg::WAKE_CYCLES)))
    else $error("settling length differs from both limits");
endmodule : tcsc_top
`default_nettype wire

// >>> rtl/tcsc_pkg.sv
package tcsc_pkg;
  // ------------------------------------------------------------
  // Word layout
  // ------------------------------------------------------------
  localparam int WORD_BITS = 8;
  localparam int CAP_BITS = 5;
  localparam int CAP_LSB_POS = 0;
  localparam int CAP_MSB_POS = 4;
  localparam int STANDBY_POS = 5;
  localparam int RSVD_LO_POS = 6;
  localparam int RSVD_HI_POS = 7;
  localparam logic [7:0] WORD_RESET = 8'h00;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 20000;
  localparam int SETTLE_TIME_US = 10;
  localparam int WAKE_TIME_US = 100;
  localparam int SETTLE_CYCLES = (SETTLE_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int WAKE_CYCLES = (WAKE_TIME_US * 1000000) / CLK_PERIOD_PS;
  localparam int TIMER_BITS = 13;
  localparam logic [12:0] TIMER_RESET = 13'h0000;

  typedef struct packed {
    logic standby_request;
    logic [4:0] cap_state;
  } tcsc_setting_s;

  typedef enum logic [1:0] {
    TCSC_IDLE = 2'b00,
    TCSC_SETTLE = 2'b01,
    TCSC_WAKE = 2'b10
  } tcsc_state_e;
endpackage : tcsc_pkg

// >>> rtl/tcsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tcsc_sync #(
  parameter int WIDTH = 3
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Active-low reset
  input wire logic [WIDTH-1:0] async_in, // Pins from outside
  output logic [WIDTH-1:0] sync_out // Synchronised copy
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : tcsc_sync
`default_nettype wire

// >>> sim/tcsc_master.sv
`timescale 1ns/1ps
`default_nettype none
module tcsc_master (
  input wire logic mclk, // Bench clock, paces the link
  output logic serial_select, // Select, active high
  output logic serial_clock, // Shift clock, low between frames except when stray pulses it
  output logic serial_data // Data, moved on clock fall
);
  initial begin
    serial_select = 1'b0;
    serial_clock = 1'b0;
    serial_data = 1'b0;
  end
  // --------------------------------------------------------
  // Link timing: 80 ns half period
  // --------------------------------------------------------
  task automatic half();
    repeat (4) @(posedge mclk);
    #1;
  endtask : half
  task automatic send(input logic [15:0] v, input logic long16);
    int n;
    n = long16 ? 16 : 8;
    // Select stays low a while after any earlier frame
    half();
    serial_select = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data = v[i];
      half();
      serial_clock = 1'b1;
      half();
      serial_clock = 1'b0;
    end
  endtask : send
  task automatic finish_frame();
    // Clock rests low a while before select drops
    half();
    serial_select = 1'b0;
    // Released data no longer shows the last bit
    serial_data = ~serial_data;
  endtask : finish_frame
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      serial_data = ~serial_data;
      half();
      serial_clock = 1'b1;
      half();
      serial_clock = 1'b0;
    end
  endtask : stray
endmodule : tcsc_master
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk, rstn, serial_select, serial_clock, serial_data;
  logic standby_request, apply_pulse, settled;
  logic [4:0] cap_state;
  logic [7:0] shift_word, exp_word;
  int miscompares = 0;
  int checks = 0;
  tcsc_top i_tcsc_top (.mclk(mclk), .rstn(rstn),
    .serial_select(serial_select), .serial_clock(serial_clock),
    .serial_data(serial_data), .cap_state(cap_state),
    .standby_request(standby_request), .apply_pulse(apply_pulse),
    .settled(settled), .shift_word(shift_word));
  tcsc_master i_tcsc_master (.mclk(mclk), .serial_select(serial_select),
    .serial_clock(serial_clock), .serial_data(serial_data));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // --------------------------------------------------------
  // Checking helpers
  // --------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apply(input logic [15:0] v, input logic l, input int wn);
    int k;
    i_tcsc_master.send(v, l);
    chk("shift_word", v[7:0], shift_word);
    chk("held_setting", {2'h0, exp_word[5:0]},
      {2'h0, standby_request, cap_state});
    i_tcsc_master.finish_frame();
    for (k = 0; k < 20 && apply_pulse !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    chk("apply_pulse", 8'h01, {7'h0, apply_pulse});
    if (k == 20) stop_test();
    exp_word = v[7:0];
    chk("cap_state", {3'h0, v[4:0]}, {3'h0, cap_state});
    chk("standby", {7'h0, v[5]}, {7'h0, standby_request});
    for (k = 0; k < 6000 && settled !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    if (k == 6000) begin
      chk("settled", 8'h01, {7'h0, settled});
      stop_test();
    end
    chk("settle_len", 8'h01, {7'h0, k >= wn - 3 && k <= wn + 1});
  endtask : apply
  initial begin
    rstn = 1'b0;
    exp_word = 8'h00;
    repeat (2) @(posedge mclk);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk("reset_word", 8'h00, shift_word);
    chk("reset_set", 8'h00, {2'h0, standby_request, cap_state});
    chk("reset_settled", 8'h01, {7'h0, settled});
    for (int i = 1; i < 32; i++) begin
      apply({11'h000, i[4:0]}, 1'b0, tcsc_pkg::SETTLE_CYCLES);
    end
    apply(16'h003F, 1'b0, tcsc_pkg::SETTLE_CYCLES);
    apply(16'h0001, 1'b0, tcsc_pkg::WAKE_CYCLES);
    apply(16'hE71B, 1'b1, tcsc_pkg::SETTLE_CYCLES);
    i_tcsc_master.stray(3);
    repeat (4) @(posedge mclk);
    #1;
    chk("stray_word", 8'h1B, shift_word);
    chk("stray_set", 8'h1B, {2'h0, standby_request, cap_state});
    stop_test();
  end
endmodule : tb
`default_nettype wire
